// ---- spc_pkg.sv ----
package spc_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_CONTROL    = 8'h00;
	localparam logic [7:0] ADDR_STATUS     = 8'h04;
	localparam logic [7:0] ADDR_TX_DATA    = 8'h08;
	localparam logic [7:0] ADDR_RX_DATA    = 8'h0c;
	localparam logic [7:0] ADDR_MODE       = 8'h10;
	localparam logic [7:0] ADDR_INT_STATUS = 8'h14;
	localparam logic [7:0] ADDR_INT_MASK   = 8'h18;

	// control register fields
	localparam int CTRL_TX_IRQ_EN = 7;
	localparam int CTRL_RX_IRQ_EN = 6;
	localparam int CTRL_TX_EN     = 5;
	localparam int CTRL_RX_EN     = 4;

	// status register fields
	localparam int ST_TX_EMPTY = 7;
	localparam int ST_RX_FULL  = 6;
	localparam int ST_OVERRUN  = 5;
	localparam int ST_FRAMING  = 4;
	localparam int ST_PARITY   = 3;

	// mode register fields
	localparam int MODE_SYNC      = 7;
	localparam int MODE_PARITY_EN = 5;
	localparam int MODE_ODD       = 4;

	// event bits of interrupt status and mask
	localparam int EV_TX  = 0;
	localparam int EV_RX  = 1;
	localparam int EV_ERR = 2;
	localparam int EV_W   = 3;

	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET    = 8'h00;
	localparam logic [7:0] DATA_RESET    = 8'h00;

	localparam logic [3:0] FRAME_BITS_ASYNC_PAR = 4'h9;
	localparam logic [3:0] FRAME_BITS_PLAIN     = 4'h8;
	localparam logic [3:0] TX_LEN_ASYNC_PAR     = 4'hb;
	localparam logic [3:0] TX_LEN_ASYNC         = 4'ha;
	localparam logic [3:0] TX_LEN_SYNC          = 4'h8;

	// timing
	localparam int CLOCK_HZ    = 10000000;
	localparam int BIT_RATE    = 9600;
	localparam int BIT_CYCLES  = CLOCK_HZ / BIT_RATE;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b11,
		RX_STOP  = 2'b10
	} spc_rx_state_type;
endpackage : spc_pkg

// ---- spc_serial_ctrl.sv ----
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
// Contract
// - tx irq needs enable and empty flag
// - tx irq ends by flag clear or disable
// - rx irq enable gates full and error
// - rx irqs end by flag clear or disable
// - tx disabled holds empty flag at one
// - clearing empty flag starts transmission
// - rx disable keeps receive flags unchanged
// - rx starts on start bit or clock
// - control register always readable and writable
module spc_serial_ctrl #(
	parameter int BIT_CYCLES = spc_pkg::BIT_CYCLES
) (
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [31:0] i_wb_dat,
	input  wire logic [3:0]  i_wb_sel,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	input  wire logic        i_rxd,
	input  wire logic        i_sck,
	output logic             o_txd,
	output logic             o_tx_empty_irq,
	output logic             o_rx_full_irq,
	output logic             o_rx_error_irq,
	output logic             o_irq
);
	localparam int TW = $clog2(BIT_CYCLES + 1);
	localparam logic [TW-1:0] FULL_BIT = TW'(BIT_CYCLES - 1);
	localparam logic [TW-1:0] HALF_BIT = TW'(BIT_CYCLES / 2);

	logic [7:0]                  serial_control;
	logic [7:0]                  serial_mode;
	logic [7:0]                  tx_data_reg;
	logic [7:0]                  rx_data_reg;
	logic                        tx_empty_flag;
	logic                        rx_full_flag;
	logic                        framing_error_flag;
	logic                        parity_error_flag;
	logic                        overrun_error_flag;
	logic [7:0]                  status;
	logic [7:0]                  seen;
	logic [7:0]                  clear_req;
	logic [spc_pkg::EV_W-1:0]    int_status;
	logic [spc_pkg::EV_W-1:0]    int_mask;
	logic [spc_pkg::EV_W-1:0]    events;
	logic                        rxd_s1, rxd_s2, rxd_d;
	logic                        sck_s1, sck_s2, sck_d;
	logic                        tx_busy, tx_first;
	logic [3:0]                  tx_left;
	logic [10:0]                 tx_shift;
	logic [TW-1:0]               tx_timer;
	spc_pkg::spc_rx_state_type   rx_state;
	logic [TW-1:0]               rx_timer;
	logic [3:0]                  rx_count;
	logic [8:0]                  rx_shift;
	logic                        rx_done;
	logic [7:0]                  rx_word;
	logic                        rx_bad_stop, rx_bad_par;

	wire tx_irq_enable = serial_control[spc_pkg::CTRL_TX_IRQ_EN];
	wire rx_irq_enable = serial_control[spc_pkg::CTRL_RX_IRQ_EN];
	wire tx_enable     = serial_control[spc_pkg::CTRL_TX_EN];
	wire rx_enable     = serial_control[spc_pkg::CTRL_RX_EN];
	wire sync_mode     = serial_mode[spc_pkg::MODE_SYNC];
	wire parity_en     = serial_mode[spc_pkg::MODE_PARITY_EN] & ~sync_mode;
	wire odd_parity    = serial_mode[spc_pkg::MODE_ODD];

	// bus: reads sampled on the request cycle, writes land on the ack edge
	wire bus_req  = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	wire bus_wr   = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack & i_wb_sel[0];
	wire rd_stat  = bus_req & ~i_wb_we & (i_wb_adr == spc_pkg::ADDR_STATUS);
	wire wr_ctrl  = bus_wr & (i_wb_adr == spc_pkg::ADDR_CONTROL);
	wire wr_stat  = bus_wr & (i_wb_adr == spc_pkg::ADDR_STATUS);
	wire wr_txd   = bus_wr & (i_wb_adr == spc_pkg::ADDR_TX_DATA);
	wire wr_mode  = bus_wr & (i_wb_adr == spc_pkg::ADDR_MODE);
	wire wr_istat = bus_wr & (i_wb_adr == spc_pkg::ADDR_INT_STATUS);
	wire wr_imask = bus_wr & (i_wb_adr == spc_pkg::ADDR_INT_MASK);

	// link inputs
	wire sck_rise = sck_s2 & ~sck_d;
	wire sck_fall = ~sck_s2 & sck_d;
	wire rxd_fall = ~rxd_s2 & rxd_d;

	wire tx_load  = tx_enable & ~tx_empty_flag & ~tx_busy;
	wire tx_step  = tx_first | (sync_mode ? sck_fall : (tx_timer == '0));
	wire rx_xfer  = rx_done & rx_enable;
	wire rx_fresh = rx_xfer & ~rx_full_flag;
	wire rx_over  = rx_xfer & rx_full_flag;
	wire [8:0] next_rx_shift = {rxd_s2, rx_shift[8:1]};
	wire [3:0] rx_frame_bits = parity_en ? spc_pkg::FRAME_BITS_ASYNC_PAR
	                                     : spc_pkg::FRAME_BITS_PLAIN;
	wire rx_sample = sync_mode ? sck_rise : (rx_timer == '0);

	always_comb begin
		status = 8'h00;
		status[spc_pkg::ST_TX_EMPTY] = tx_empty_flag;
		status[spc_pkg::ST_RX_FULL]  = rx_full_flag;
		status[spc_pkg::ST_OVERRUN]  = overrun_error_flag;
		status[spc_pkg::ST_FRAMING]  = framing_error_flag;
		status[spc_pkg::ST_PARITY]   = parity_error_flag;
	end

	// a zero written clears a flag only after it was read as one
	assign clear_req = seen & ~i_wb_dat[7:0] & {8{wr_stat}};

	assign o_tx_empty_irq = tx_empty_flag & tx_irq_enable;
	assign o_rx_full_irq  = rx_full_flag & rx_irq_enable;
	assign o_rx_error_irq = (framing_error_flag | parity_error_flag
	                        | overrun_error_flag) & rx_irq_enable;
	assign o_irq          = |(int_status & int_mask);

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end else begin
			o_wb_ack <= bus_req;
			if (bus_req) begin
				o_wb_dat <= 32'h0000_0000;
				case (i_wb_adr)
					spc_pkg::ADDR_CONTROL:    o_wb_dat[7:0] <= serial_control;
					spc_pkg::ADDR_STATUS:     o_wb_dat[7:0] <= status;
					spc_pkg::ADDR_TX_DATA:    o_wb_dat[7:0] <= tx_data_reg;
					spc_pkg::ADDR_RX_DATA:    o_wb_dat[7:0] <= rx_data_reg;
					spc_pkg::ADDR_MODE:       o_wb_dat[7:0] <= serial_mode;
					spc_pkg::ADDR_INT_STATUS: o_wb_dat[spc_pkg::EV_W-1:0] <= int_status;
					spc_pkg::ADDR_INT_MASK:   o_wb_dat[spc_pkg::EV_W-1:0] <= int_mask;
					default:                  o_wb_dat <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			serial_control <= spc_pkg::CONTROL_RESET;
			serial_mode    <= spc_pkg::MODE_RESET;
			tx_data_reg    <= spc_pkg::DATA_RESET;
			int_mask       <= '0;
		end else begin
			if (wr_ctrl) begin
				serial_control <= i_wb_dat[7:0];
			end
			if (wr_mode) begin
				serial_mode <= i_wb_dat[7:0];
			end
			if (wr_txd) begin
				tx_data_reg <= i_wb_dat[7:0];
			end
			if (wr_imask) begin
				int_mask <= i_wb_dat[spc_pkg::EV_W-1:0];
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			seen <= 8'h00;
		end else begin
			seen <= status & (seen | {8{rd_stat}});
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			tx_empty_flag <= 1'b1;
		end else if (!tx_enable) begin
			tx_empty_flag <= 1'b1;
		end else if (tx_load) begin
			tx_empty_flag <= 1'b1;
		end else if (clear_req[spc_pkg::ST_TX_EMPTY]) begin
			tx_empty_flag <= 1'b0;
		end
	end

	// receive flags: only the receiver sets them, set wins over clear
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			rx_full_flag       <= 1'b0;
			overrun_error_flag <= 1'b0;
			framing_error_flag <= 1'b0;
			parity_error_flag  <= 1'b0;
			rx_data_reg        <= spc_pkg::DATA_RESET;
		end else begin
			if (rx_fresh) begin
				rx_full_flag <= 1'b1;
				rx_data_reg  <= rx_word;
			end else if (clear_req[spc_pkg::ST_RX_FULL]) begin
				rx_full_flag <= 1'b0;
			end
			if (rx_over) begin
				overrun_error_flag <= 1'b1;
			end else if (clear_req[spc_pkg::ST_OVERRUN]) begin
				overrun_error_flag <= 1'b0;
			end
			if (rx_fresh & rx_bad_stop) begin
				framing_error_flag <= 1'b1;
			end else if (clear_req[spc_pkg::ST_FRAMING]) begin
				framing_error_flag <= 1'b0;
			end
			if (rx_fresh & rx_bad_par) begin
				parity_error_flag <= 1'b1;
			end else if (clear_req[spc_pkg::ST_PARITY]) begin
				parity_error_flag <= 1'b0;
			end
		end
	end

	assign events = {rx_over | (rx_fresh & (rx_bad_stop | rx_bad_par)), rx_fresh, tx_load};

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			int_status <= '0;
		end else begin
			int_status <= (int_status & ~(i_wb_dat[spc_pkg::EV_W-1:0] & {spc_pkg::EV_W{wr_istat}}))
			              | events;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			rxd_s1 <= 1'b1;
			rxd_s2 <= 1'b1;
			rxd_d  <= 1'b1;
			sck_s1 <= 1'b1;
			sck_s2 <= 1'b1;
			sck_d  <= 1'b1;
		end else begin
			rxd_s1 <= i_rxd;
			rxd_s2 <= rxd_s1;
			rxd_d  <= rxd_s2;
			sck_s1 <= i_sck;
			sck_s2 <= sck_s1;
			sck_d  <= sck_s2;
		end
	end

	// transmitter: lsb first; async adds start, optional parity, stop
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			tx_busy  <= 1'b0;
			tx_first <= 1'b0;
			tx_left  <= 4'h0;
			tx_shift <= 11'h7ff;
			tx_timer <= '0;
			o_txd    <= 1'b1;
		end else if (!tx_enable) begin
			tx_busy  <= 1'b0;
			tx_first <= 1'b0;
			o_txd    <= 1'b1;
		end else if (tx_load) begin
			tx_busy  <= 1'b1;
			tx_first <= 1'b1;
			tx_timer <= '0;
			if (sync_mode) begin
				tx_shift <= {3'b111, tx_data_reg};
				tx_left  <= spc_pkg::TX_LEN_SYNC;
			end else if (parity_en) begin
				tx_shift <= {1'b1, ^tx_data_reg ^ odd_parity, tx_data_reg, 1'b0};
				tx_left  <= spc_pkg::TX_LEN_ASYNC_PAR;
			end else begin
				tx_shift <= {2'b11, tx_data_reg, 1'b0};
				tx_left  <= spc_pkg::TX_LEN_ASYNC;
			end
		end else if (tx_busy) begin
			if (tx_step) begin
				tx_first <= 1'b0;
				tx_timer <= FULL_BIT;
				if (tx_left == 4'h0) begin
					tx_busy <= 1'b0;
					o_txd   <= 1'b1;
				end else begin
					o_txd    <= tx_shift[0];
					tx_shift <= {1'b1, tx_shift[10:1]};
					tx_left  <= tx_left - 4'h1;
				end
			end else if (tx_timer != '0) begin
				tx_timer <= tx_timer - TW'(1);
			end
		end
	end

	// receiver
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			rx_state    <= spc_pkg::RX_IDLE;
			rx_timer    <= '0;
			rx_count    <= 4'h0;
			rx_shift    <= 9'h000;
			rx_done     <= 1'b0;
			rx_word     <= 8'h00;
			rx_bad_stop <= 1'b0;
			rx_bad_par  <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (!rx_enable) begin
				rx_state <= spc_pkg::RX_IDLE;
			end else begin
				case (rx_state)
					spc_pkg::RX_IDLE: begin
						if (sync_mode) begin
							if (sck_rise) begin
								rx_shift <= next_rx_shift;
								rx_count <= 4'h1;
								rx_state <= spc_pkg::RX_DATA;
							end
						end else if (rxd_fall) begin
							rx_timer <= HALF_BIT;
							rx_state <= spc_pkg::RX_START;
						end
					end
					spc_pkg::RX_START: begin
						if (rx_timer != '0) begin
							rx_timer <= rx_timer - TW'(1);
						end else if (!rxd_s2) begin
							rx_timer <= FULL_BIT;
							rx_count <= 4'h0;
							rx_state <= spc_pkg::RX_DATA;
						end else begin
							rx_state <= spc_pkg::RX_IDLE;
						end
					end
					spc_pkg::RX_DATA: begin
						if (rx_sample) begin
							rx_shift <= next_rx_shift;
							rx_count <= rx_count + 4'h1;
							rx_timer <= FULL_BIT;
							if (rx_count + 4'h1 == rx_frame_bits) begin
								if (sync_mode) begin
									rx_done     <= 1'b1;
									rx_word     <= next_rx_shift[8:1];
									rx_bad_stop <= 1'b0;
									rx_bad_par  <= 1'b0;
									rx_state    <= spc_pkg::RX_IDLE;
								end else begin
									rx_state <= spc_pkg::RX_STOP;
								end
							end
						end else if (!sync_mode && rx_timer != '0) begin
							rx_timer <= rx_timer - TW'(1);
						end
					end
					spc_pkg::RX_STOP: begin
						if (rx_timer != '0) begin
							rx_timer <= rx_timer - TW'(1);
						end else begin
							rx_done     <= 1'b1;
							rx_word     <= parity_en ? rx_shift[7:0] : rx_shift[8:1];
							rx_bad_stop <= ~rxd_s2;
							rx_bad_par  <= parity_en & (^rx_shift ^ odd_parity);
							rx_state    <= spc_pkg::RX_IDLE;
						end
					end
					default: rx_state <= spc_pkg::RX_IDLE;
				endcase
			end
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	tx_irq_gate_a: assert property (
		tx_irq_enable && tx_empty_flag |-> o_tx_empty_irq
	) else $error("tx irq missing while enabled and empty");

	tx_irq_remove_a: assert property (
		$fell(tx_irq_enable) || $fell(tx_empty_flag) |-> !o_tx_empty_irq
	) else $error("tx irq stayed after clear");

	rx_irq_set_a: assert property (
		rx_fresh && rx_irq_enable && !wr_ctrl |=> o_rx_full_irq
	) else $error("rx full irq not raised");

	rx_irq_remove_a: assert property (
		$fell(rx_irq_enable) |-> !o_rx_full_irq && !o_rx_error_irq
	) else $error("rx irqs stayed after enable cleared");

	tx_held_empty_a: assert property (
		!tx_enable |=> tx_empty_flag && o_txd
	) else $error("tx empty not held while disabled");

	tx_start_a: assert property (
		tx_enable && !tx_empty_flag && !tx_busy && !wr_ctrl && !sync_mode
		|=> tx_busy ##1 !o_txd || !tx_enable
	) else $error("transmission did not start");

	rx_flags_keep_a: assert property (
		!rx_enable && !wr_stat |=> $stable({rx_full_flag, framing_error_flag,
		                                    parity_error_flag, overrun_error_flag})
	) else $error("rx flags changed while disabled");

	rx_start_a: assert property (
		rx_enable && !sync_mode && rx_state == spc_pkg::RX_IDLE && rxd_fall && !wr_ctrl
		|=> rx_state == spc_pkg::RX_START
	) else $error("start bit not detected");

	ctrl_access_a: assert property (
		wr_ctrl |=> serial_control == $past(i_wb_dat[7:0])
	) else $error("control write lost");

	bus_ack_a: assert property (
		bus_req |=> o_wb_ack ##1 !o_wb_ack
	) else $error("bus ack not one cycle after request");

	irq_and_a: assert property (
		$fell(rx_full_flag) && !framing_error_flag |-> !o_rx_full_irq
	) else $error("rx irq not dropped with flag");
endmodule : spc_serial_ctrl

// ---- spc_line_partner.sv ----
`timescale 1ns/1ps
module spc_line_partner #(
	parameter int BIT_NS = 800
) (
	input  wire logic i_txd,
	output logic      o_rxd,
	output logic      o_sck
);
	// line and sync clock idle high; the clock runs only inside a frame
	initial begin
		o_rxd = 1'b1;
		o_sck = 1'b1;
	end

	// start, 8 bits lsb first, chosen stop level
	task automatic send_frame(input logic [7:0] data, input logic stop);
		#(BIT_NS / 7);
		o_rxd = 1'b0;
		#(BIT_NS);
		for (int i = 0; i < 8; i++) begin
			o_rxd = data[i];
			#(BIT_NS);
		end
		o_rxd = stop;
		#(BIT_NS);
		o_rxd = 1'b1;
	endtask : send_frame

	// clocked synchronous: data set while the clock is low, taken on the rise
	task automatic send_sync(input logic [7:0] data);
		for (int i = 0; i < 8; i++) begin
			o_rxd = data[i];
			o_sck = 1'b0;
			#(BIT_NS / 2);
			o_sck = 1'b1;
			#(BIT_NS / 2);
		end
		o_rxd = 1'b1;
	endtask : send_sync

	// bounded wait for a start bit, then mid-bit sampling
	task automatic recv_frame(output logic [7:0] data, output logic stop, output logic ok);
		int n;
		data = 8'h00;
		stop = 1'b0;
		for (n = 0; n < 4000 && i_txd !== 1'b0; n++) begin
			#10;
		end
		ok = (i_txd === 1'b0);
		if (!ok) begin
			return;
		end
		#(BIT_NS + BIT_NS / 2);
		for (int i = 0; i < 8; i++) begin
			data[i] = i_txd;
			#(BIT_NS);
		end
		stop = i_txd;
	endtask : recv_frame
endmodule : spc_line_partner

// ---- serial_port_enable_irq_control_test.sv ----
`timescale 1ns/1ps
module serial_port_enable_irq_control_test;
	localparam int BITS = 8;
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] status;
		logic [2:0] irqs;
	} spc_row_type;
	logic        clock;
	logic        rst_n;
	logic        wb_cyc;
	logic        wb_stb;
	logic        wb_we;
	logic [7:0]  wb_adr;
	logic [31:0] wb_wdat;
	logic [31:0] wb_rdat;
	logic        wb_ack;
	logic        rxd;
	logic        sck;
	logic        txd;
	logic        tx_irq;
	logic        rx_irq;
	logic        err_irq;
	logic        irq;
	logic [31:0] rd;
	logic [7:0]  got;
	logic        stop;
	logic        ok;
	int          errors;
	int          checks;
	spc_row_type rows [5] = '{
		'{8'h00, 8'h80, 3'b000},
		'{8'h80, 8'h80, 3'b100},
		'{8'h40, 8'h80, 3'b000},
		'{8'ha0, 8'h80, 3'b100},
		'{8'h6f, 8'h80, 3'b000}
	};

	spc_serial_ctrl #(.BIT_CYCLES(BITS)) uut (
		.i_clock(clock), .i_rst_n(rst_n), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
		.i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_dat(wb_wdat), .i_wb_sel(4'h1),
		.o_wb_dat(wb_rdat), .o_wb_ack(wb_ack), .i_rxd(rxd), .i_sck(sck), .o_txd(txd),
		.o_tx_empty_irq(tx_irq), .o_rx_full_irq(rx_irq), .o_rx_error_irq(err_irq),
		.o_irq(irq)
	);
	spc_line_partner #(.BIT_NS(BITS * 100)) line (.i_txd(txd), .o_rxd(rxd), .o_sck(sck));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// one classic cycle, held until ack is sampled
	task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_wdat <= d;
		for (n = 0; n < 16; n++) begin
			@(posedge clock);
			if (wb_ack === 1'b1) begin
				break;
			end
		end
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		// a write lands on the ack edge: let it settle before any check
		@(negedge clock);
		if (n == 16) begin
			errors++;
			report_and_stop();
		end
	endtask : wb_cycle

	task automatic read_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
		wb_cycle(1'b0, a, 32'h0000_0000);
		check(name, {24'h00_0000, exp}, rd);
	endtask : read_chk

	initial begin
		rst_n = 1'b0;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_wdat = 32'h0000_0000;
		errors = 0;
		checks = 0;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		read_chk(spc_pkg::ADDR_CONTROL, 8'h00, "control reset");
		read_chk(spc_pkg::ADDR_STATUS, 8'h80, "status reset");
		check("reset lines", 32'h0000_0008, 32'({txd, tx_irq, rx_irq, err_irq}));
		wb_cycle(1'b1, spc_pkg::ADDR_MODE, 32'h0000_0000);
		foreach (rows[i]) begin
			wb_cycle(1'b1, spc_pkg::ADDR_CONTROL, 32'(rows[i].ctrl));
			read_chk(spc_pkg::ADDR_CONTROL, rows[i].ctrl, "control");
			read_chk(spc_pkg::ADDR_STATUS, rows[i].status, "status");
			check("irqs", 32'(rows[i].irqs), 32'({tx_irq, rx_irq, err_irq}));
		end
		read_chk(8'h1c, 8'h00, "unmapped");
		// transmit one frame
		wb_cycle(1'b1, spc_pkg::ADDR_CONTROL, 32'h0000_00a0);
		wb_cycle(1'b1, spc_pkg::ADDR_TX_DATA, 32'h0000_00a5);
		read_chk(spc_pkg::ADDR_STATUS, 8'h80, "status");
		fork
			line.recv_frame(got, stop, ok);
			wb_cycle(1'b1, spc_pkg::ADDR_STATUS, 32'h0000_0000);
		join
		check("tx frame", 32'h0000_03a5, 32'({ok, stop, got}));
		check("tx irq", 32'h0000_0001, 32'(tx_irq));
		wb_cycle(1'b1, spc_pkg::ADDR_CONTROL, 32'h0000_0020);
		check("tx irq", 32'h0000_0000, 32'(tx_irq));
		read_chk(spc_pkg::ADDR_INT_STATUS, 8'h01, "int status");
		// abort a frame by disabling the transmitter
		wb_cycle(1'b1, spc_pkg::ADDR_TX_DATA, 32'h0000_0000);
		read_chk(spc_pkg::ADDR_STATUS, 8'h80, "status");
		wb_cycle(1'b1, spc_pkg::ADDR_STATUS, 32'h0000_0000);
		repeat (BITS * 3) @(negedge clock);
		check("txd busy", 32'h0000_0000, 32'(txd));
		wb_cycle(1'b1, spc_pkg::ADDR_CONTROL, 32'h0000_0000);
		read_chk(spc_pkg::ADDR_STATUS, 8'h80, "status");
		check("txd idle", 32'h0000_0001, 32'(txd));
		wb_cycle(1'b1, spc_pkg::ADDR_INT_STATUS, 32'h0000_0007);
		// receive disabled, then enabled
		wb_cycle(1'b1, spc_pkg::ADDR_CONTROL, 32'h0000_0040);
		line.send_frame(8'h3c, 1'b1);
		repeat (BITS) @(posedge clock);
		read_chk(spc_pkg::ADDR_STATUS, 8'h80, "status");
		wb_cycle(1'b1, spc_pkg::ADDR_CONTROL, 32'h0000_0050);
		line.send_frame(8'h3c, 1'b1);
		repeat (BITS) @(posedge clock);
		check("rx irq", 32'h0000_0001, 32'(rx_irq));
		read_chk(spc_pkg::ADDR_RX_DATA, 8'h3c, "rx data");
		wb_cycle(1'b1, spc_pkg::ADDR_CONTROL, 32'h0000_0040);
		read_chk(spc_pkg::ADDR_STATUS, 8'hc0, "status");
		wb_cycle(1'b1, spc_pkg::ADDR_CONTROL, 32'h0000_0010);
		check("rx irq", 32'h0000_0000, 32'(rx_irq));
		wb_cycle(1'b1, spc_pkg::ADDR_CONTROL, 32'h0000_0050);
		wb_cycle(1'b1, spc_pkg::ADDR_STATUS, 32'h0000_0000);
		check("rx irq", 32'h0000_0000, 32'(rx_irq));
		// framing error, then overrun
		line.send_frame(8'h55, 1'b0);
		repeat (BITS) @(posedge clock);
		read_chk(spc_pkg::ADDR_STATUS, 8'hd0, "status");
		check("irqs", 32'h0000_0003, 32'({tx_irq, rx_irq, err_irq}));
		line.send_frame(8'h11, 1'b1);
		repeat (BITS) @(posedge clock);
		read_chk(spc_pkg::ADDR_STATUS, 8'hf0, "status");
		read_chk(spc_pkg::ADDR_RX_DATA, 8'h55, "rx data");
		wb_cycle(1'b1, spc_pkg::ADDR_STATUS, 32'h0000_0000);
		check("irqs", 32'h0000_0000, 32'({tx_irq, rx_irq, err_irq}));
		read_chk(spc_pkg::ADDR_INT_STATUS, 8'h06, "int status");
		wb_cycle(1'b1, spc_pkg::ADDR_INT_MASK, 32'h0000_0004);
		check("irq", 32'h0000_0001, 32'(irq));
		wb_cycle(1'b1, spc_pkg::ADDR_INT_STATUS, 32'h0000_0004);
		check("irq", 32'h0000_0000, 32'(irq));
		// parity error, then a clocked synchronous frame
		wb_cycle(1'b1, spc_pkg::ADDR_CONTROL, 32'h0000_0040);
		wb_cycle(1'b1, spc_pkg::ADDR_MODE, 32'h0000_0020);
		wb_cycle(1'b1, spc_pkg::ADDR_CONTROL, 32'h0000_0050);
		line.send_frame(8'h3c, 1'b1);
		repeat (BITS * 2) @(negedge clock);
		check("irqs", 32'h0000_0003, 32'({tx_irq, rx_irq, err_irq}));
		read_chk(spc_pkg::ADDR_STATUS, 8'hc8, "status");
		read_chk(spc_pkg::ADDR_RX_DATA, 8'h3c, "rx data");
		wb_cycle(1'b1, spc_pkg::ADDR_STATUS, 32'h0000_0000);
		wb_cycle(1'b1, spc_pkg::ADDR_CONTROL, 32'h0000_0040);
		wb_cycle(1'b1, spc_pkg::ADDR_MODE, 32'h0000_0080);
		wb_cycle(1'b1, spc_pkg::ADDR_CONTROL, 32'h0000_0050);
		line.send_sync(8'h96);
		repeat (BITS) @(negedge clock);
		check("irqs", 32'h0000_0002, 32'({tx_irq, rx_irq, err_irq}));
		read_chk(spc_pkg::ADDR_STATUS, 8'hc0, "status");
		read_chk(spc_pkg::ADDR_RX_DATA, 8'h96, "rx data");
		// reset in mid-run
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		read_chk(spc_pkg::ADDR_CONTROL, 8'h00, "control reset");
		read_chk(spc_pkg::ADDR_STATUS, 8'h80, "status reset");
		check("reset lines", 32'h0000_0008, 32'({txd, tx_irq, rx_irq, err_irq}));
		check("irq", 32'h0000_0000, 32'(irq));
		report_and_stop();
	end
endmodule : serial_port_enable_irq_control_test
